// ===== bench/casb_bank_sva.sv
/* Port checker for the aux register bank: pointer outputs, strobe
   gating and read-channel behaviour. Assumes one clock and one reset. */
`timescale 1ns/1ps
`include "casb_defs.vh"
module casb_bank_sva (
  input wire clk,
  input wire arst_n,
  input wire s_axi_arvalid,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [2:0] ptrOp,
  input wire xdataWrite,
  input wire [7:0] accValue,
  input wire strobeReq,
  input wire strobeOut,
  input wire memRead,
  input wire memWrite,
  input wire memCode,
  input wire [7:0] memWdata,
  input wire jumpValid
);
  // Single domain, so clock and reset are named once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ****************************
  // Core-side pointer and strobe
  // ****************************
  a_strobe_gate: assert property (
    strobeOut |-> $past(strobeReq)) else $error("strobe without request");
  a_xread_cause: assert property (
    memRead |-> $past(ptrOp) == `CASB_OP_XDATA && !$past(xdataWrite))
    else $error("external read without request");
  a_xwrite_data: assert property (
    memWrite |-> $past(xdataWrite) && memWdata == $past(accValue))
    else $error("external write data wrong");
  a_mem_single: assert property (
    memRead |-> !memWrite && !memCode) else $error("two accesses at once");
  a_code_cause: assert property (
    memCode |-> $past(ptrOp) == `CASB_OP_CODE)
    else $error("code fetch without request");
  a_jump_cause: assert property (
    jumpValid |-> $past(ptrOp) == `CASB_OP_JUMP)
    else $error("jump without request");
  // ****************************
  // Register read channel
  // ****************************
  a_read_answer: assert property (
    s_axi_arvalid && !s_axi_rvalid |-> ##[1:3] s_axi_rvalid)
    else $error("read not answered");
  a_rvalid_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not withdrawn after handshake");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule // casb_bank_sva

bind casb_core_aux_sfr_bank casb_bank_sva i_casb_bank_sva (
  .clk(clk), .arst_n(arst_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .ptrOp(ptrOp), .xdataWrite(xdataWrite),
  .accValue(accValue), .strobeReq(strobeReq), .strobeOut(strobeOut),
  .memRead(memRead), .memWrite(memWrite), .memCode(memCode),
  .memWdata(memWdata), .jumpValid(jumpValid)
);

// ===== bench/tb_top.sv
/* Self-checking bench for the aux register bank: registers over
   AXI4-Lite, pointer operations, strobe gating, level arbitration.
   Assumes the bank's registered bus timing and a 200 MHz clock. */
`timescale 1ns/1ps
`include "casb_defs.vh"
module tb_top;
  // ****************************
  // Signals and reference state
  // ****************************
  localparam logic [7:0] AUX = `CASB_OFF_AUX_CONTROL;
  localparam logic [7:0] SEL = `CASB_OFF_POINTER_SELECT_AUX;
  localparam logic [7:0] PHI = `CASB_OFF_PRIORITY_HIGH_BITS;
  localparam logic [7:0] PLO = `CASB_OFF_PRIORITY_LOW_BITS;
  localparam logic [7:0] DPL = `CASB_OFF_POINTER_LOW;
  localparam logic [7:0] DPH = `CASB_OFF_POINTER_HIGH;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rData;
  logic [3:0] wStrb = 4'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp, r;
  logic [2:0] ptrOp = 3'h0, irqSource;
  logic [15:0] ptrData = 16'h0, memAddr, jumpTarget, q;
  logic [7:0] accValue = 8'h0, memWdata;
  logic xdataWrite = 1'b0, strobeReq = 1'b0, irqDone = 1'b0;
  logic [5:0] irqPending = 6'h0;
  logic strobeOut, memRead, memWrite, memCode, jumpValid, irqTake;
  // Random source, fixed start so every run repeats
  logic [31:0] lfsr = 32'h38FA;
  logic [31:0] v;
  int n_fail = 0, checks = 0;
  // Model copy of both pointers
  int p[2] = '{0, 0};

  casb_core_aux_sfr_bank i_casb_core_aux_sfr_bank (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .ptrOp(ptrOp), .ptrData(ptrData), .accValue(accValue),
    .xdataWrite(xdataWrite), .strobeReq(strobeReq),
    .irqPending(irqPending), .irqDone(irqDone), .strobeOut(strobeOut),
    .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
    .memCode(memCode), .memWdata(memWdata), .jumpValid(jumpValid),
    .jumpTarget(jumpTarget), .irqTake(irqTake), .irqSource(irqSource)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ****************************
  // Helpers
  // ****************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Register index to byte address, one word each
  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBus(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  task automatic chkPin(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A wait that runs out ends the run at once
  task automatic tmo;
    n_fail++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axiW(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (!bValid);
    rs = bResp;
    bReady <= 1'b0;
  endtask
  // Ready offered with the address and held until the answer comes
  task automatic axiR(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (!rValid);
    d = rData;
    rs = rResp;
    rReady <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    axiW(ad(i), d, 4'hF, r);
    chkBus(r, `CASB_RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    axiR(ad(i), v, r);
    chkBus(r, `CASB_RESP_OKAY);
    chkBus(v, e);
  endtask
  // One-cycle core request; outputs settle after the next edge
  task automatic op(input logic [2:0] o, input logic [15:0] d,
                    input logic [7:0] a, input logic w);
    @(posedge clk);
    ptrOp <= o;
    ptrData <= d;
    accValue <= a;
    xdataWrite <= w;
    @(posedge clk);
    ptrOp <= `CASB_OP_NONE;
    #1;
  endtask
  task automatic waitTake(input logic [2:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) tmo();
    end while (irqTake !== 1'b1);
    chkPin(irqSource, e);
  endtask
  task automatic quiet;
    int c;
    c = 0;
    repeat (8) begin
      @(posedge clk);
      if (irqTake !== 1'b0) c++;
    end
    chkPin(c, 0);
  endtask
  task automatic endIrq;
    @(posedge clk);
    irqDone <= 1'b1;
    @(posedge clk);
    irqDone <= 1'b0;
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(AUX, 32'h0);
    rd(SEL, 32'h0);
    rd(PHI, 32'h0);
    rd(PLO, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr(PHI, lfsr);
      wr(PLO, ~lfsr);
      rd(PHI, lfsr & 32'h3F);
      rd(PLO, ~lfsr & 32'h3F);
    end
    strobeReq <= 1'b1;
    wr(AUX, 32'h1);
    repeat (2) @(posedge clk);
    #1 chkPin(strobeOut, 1'b0);
    wr(AUX, 32'h0);
    repeat (2) @(posedge clk);
    #1 chkPin(strobeOut, 1'b1);
    // Refused and masked writes must leave the control word alone
    axiW(ad(AUX) + 32'h1, 32'h1, 4'hF, r);
    chkBus(r, `CASB_RESP_SLVERR);
    axiW(ad(AUX), 32'h1, 4'h0, r);
    chkBus(r, `CASB_RESP_OKAY);
    rd(AUX, 32'h0);
    axiR(ad(8'h10), v, r);
    chkBus(r, `CASB_RESP_SLVERR);
    chkBus(v, 32'h0);
    wr(SEL, 32'hFF);
    rd(SEL, 32'h9);
    // Whole-register increment flips the select, keeps the flag
    repeat (2) begin
      axiR(ad(SEL), v, r);
      chkBus(r, `CASB_RESP_OKAY);
      wr(SEL, v + 32'h1);
      rd(SEL, (v + 32'h1) & 32'h9);
    end
    for (int s = 0; s < 2; s++) begin
      wr(SEL, s);
      lfsr = nxt(lfsr);
      p[s] = lfsr[15:0];
      op(`CASB_OP_LOAD, lfsr[15:0], 8'h0, 1'b0);
    end
    for (int s = 0; s < 2; s++) begin
      wr(SEL, s);
      rd(DPL, p[s] & 32'hFF);
      rd(DPH, p[s] >> 8);
    end
    wr(DPL, 32'hFF);
    wr(DPH, 32'hFF);
    op(`CASB_OP_INC, 16'h0, 8'h0, 1'b0);
    p[1] = 0;
    rd(DPL, 32'h0);
    rd(DPH, 32'h0);
    for (int s = 0; s < 2; s++) begin
      wr(SEL, s);
      lfsr = nxt(lfsr);
      q = p[s][15:0];
      op(`CASB_OP_XDATA, 16'h0, lfsr[7:0], 1'b0);
      chkPin({memRead, memWrite, memAddr}, {2'b10, q});
      op(`CASB_OP_XDATA, 16'h0, lfsr[7:0], 1'b1);
      chkPin({memWrite, memWdata, memAddr}, {1'b1, lfsr[7:0], q});
      op(`CASB_OP_CODE, 16'h0, lfsr[15:8], 1'b0);
      chkPin({memCode, memAddr}, {1'b1, q + lfsr[15:8]});
      op(`CASB_OP_JUMP, 16'h0, lfsr[23:16], 1'b0);
      chkPin({jumpValid, jumpTarget}, {1'b1, q + lfsr[23:16]});
      op(`CASB_OP_INC, 16'h0, 8'h0, 1'b0);
      p[s] = (p[s] + 1) & 32'hFFFF;
      rd(DPL, p[s] & 32'hFF);
      rd(DPH, p[s] >> 8);
    end
    // Levels: source 0 at 1, source 1 at 2, source 5 at 3
    wr(PHI, 32'h22);
    wr(PLO, 32'h21);
    irqPending <= 6'h01;
    waitTake(3'h0);
    irqPending <= 6'h02;
    waitTake(3'h1);
    irqPending <= 6'h20;
    waitTake(3'h5);
    rd(`CASB_OFF_LEVEL_STATUS, 32'h3);
    irqPending <= 6'h02;
    quiet();
    endIrq();
    quiet();
    endIrq();
    waitTake(3'h1);
    irqPending <= 6'h00;
    report_and_stop();
  end
endmodule // tb_top

// ===== common/casb_defs.vh
/*
  Offsets, field positions, reset values and widths for the auxiliary
  special-register bank. Offsets are register indices; the 32-bit bus
  byte address is four times the index.
*/
`ifndef CASB_DEFS_VH
`define CASB_DEFS_VH

// ***************************************************************
// Special-register indices (byte address is four times the index)
// ***************************************************************
`define CASB_OFF_AUX_CONTROL 8'h8E
`define CASB_OFF_POINTER_SELECT_AUX 8'hA2
`define CASB_OFF_PRIORITY_HIGH_BITS 8'hB7
`define CASB_OFF_PRIORITY_LOW_BITS 8'hB8
`define CASB_OFF_POINTER_LOW 8'h82
`define CASB_OFF_POINTER_HIGH 8'h83
`define CASB_OFF_LEVEL_STATUS 8'hC0
`define CASB_OFF_SERVICE 8'hC4

// ***************************************************************
// Field positions
// ***************************************************************
`define CASB_BIT_STROBE_OFF 0
`define CASB_BIT_POINTER_SELECT 0
`define CASB_BIT_ZERO 2
`define CASB_BIT_USER_FLAG 3
`define CASB_PRIO_BITS 6

// ***************************************************************
// Reset values
// ***************************************************************
`define CASB_RST_AUX_CONTROL 8'h00
`define CASB_RST_PRIORITY 6'h00
`define CASB_RST_POINTER 16'h0000

// ***************************************************************
// Pointer operation codes
// ***************************************************************
`define CASB_OP_NONE 3'h0
`define CASB_OP_INC 3'h1
`define CASB_OP_LOAD 3'h2
`define CASB_OP_XDATA 3'h3
`define CASB_OP_CODE 3'h4
`define CASB_OP_JUMP 3'h5

// ***************************************************************
// Bus responses
// ***************************************************************
`define CASB_RESP_OKAY 2'h0
`define CASB_RESP_SLVERR 2'h2

`endif

// ===== hdl/casb_core_aux_sfr_bank.v
/*
  Auxiliary special-register bank: two-bit interrupt levels for six
  sources, strobe suppression, and a dual 16-bit data pointer with its
  pointer operations. Registers sit behind an AXI4-Lite slave.
  Assumes one clock; arst_n is asynchronous and released here through two
  flip-flops; core-side pointer requests come from logic on clk.
*/
// Added by the designer: the AXI4-Lite register port.
// Function
// R01 - Priority bit one raises, zero lowers
// R02 - Low priority bits 5..0, six sources
// R03 - High priority bits same order
// R04 - Priority bits 7 and 6 unimplemented
// R05 - High and low bits form level
// R06 - Preempt only on strictly higher level
// R07 - Strobe-off bit holds strobe inactive
// R08 - Two independent 16-bit data pointers
// R09 - Select bit chooses pointer, resets zero
// R10 - Select register bit 2 reads zero
// R11 - Incrementing select register toggles select
// R12 - Bit 3 general-purpose user flag
// R13 - Software saves select before switching
// R14 - Pointer instructions use selected pointer
// R15 - Increment adds one, load writes constant
// R16 - External access uses full pointer address
// R17 - Code fetch address is acc plus pointer
// R18 - Indirect jump target acc plus pointer
// R19 - Selected pointer bytes separately accessible
// R20 - Priority and control registers reset zero
`timescale 1ns/1ps
`include "casb_defs.vh"

module casb_core_aux_sfr_bank #(
  parameter NSRC = 6,
  parameter PW = 16
) (
  input wire clk,
  input wire arst_n,
  // AXI4-Lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core pointer operation request, one-cycle
  input wire [2:0] ptrOp,
  input wire [PW-1:0] ptrData,
  input wire [7:0] accValue,
  input wire xdataWrite,
  // Core address latch strobe request
  input wire strobeReq,
  // Interrupt arbitration inputs
  input wire [NSRC-1:0] irqPending,
  input wire irqDone,
  // Outputs, all registered
  output reg strobeOut,
  output reg [PW-1:0] memAddr,
  output reg memRead,
  output reg memWrite,
  output reg memCode,
  output reg [7:0] memWdata,
  output reg jumpValid,
  output reg [PW-1:0] jumpTarget,
  output reg irqTake,
  output reg [2:0] irqSource
);

  // ***************************************************************
  // Reset release
  // ***************************************************************
  reg rstSync1Reg;
  reg rstSync2Reg;
  wire rstN = rstSync2Reg;
  // Release synchroniser: assert at once, release after two edges
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1Reg <= 1'b0;
      rstSync2Reg <= 1'b0;
    end else begin
      rstSync1Reg <= 1'b1;
      rstSync2Reg <= rstSync1Reg;
    end
  end
  // ***************************************************************
  // Register state
  // ***************************************************************
  reg strobeOffReg; // Suppresses the address latch strobe
  reg [NSRC-1:0] prioLowReg; // Low-order level bits
  reg [NSRC-1:0] prioHighReg; // High-order level bits
  reg selReg; // Active pointer select
  reg userFlagReg; // General flag, no hardware effect
  reg [PW-1:0] ptrZeroReg; // Data pointer zero
  reg [PW-1:0] ptrOneReg; // Data pointer one
  reg [1:0] stackDepthReg; // Nested handlers in service
  reg [2:0] levelStackReg [0:3]; // Service level per nesting, 4 = idle
  reg awTakenReg;
  reg wTakenReg;
  reg [7:0] awAddrReg;
  reg [31:0] wDataReg;
  reg [3:0] wStrbReg;
  // Level of a source from its high and low bits
  function [1:0] srcLevel;
    input [NSRC-1:0] hi;
    input [NSRC-1:0] lo;
    input integer idx;
    begin
      // R05 level from bit pair
      srcLevel = {hi[idx], lo[idx]};
    end
  endfunction
  // Selected pointer value
  wire [PW-1:0] selPtr = selReg ? ptrOneReg : ptrZeroReg;
  // Readback of the special register bank
  function [31:0] regRead;
    input [7:0] addr;
    begin
      case (addr)
        `CASB_OFF_AUX_CONTROL: regRead = {31'h0, strobeOffReg};
        // R10 bit two reads zero
        `CASB_OFF_POINTER_SELECT_AUX:
          regRead = {28'h0, userFlagReg, 1'b0, 1'b0, selReg};
        // R04 upper bits read zero
        `CASB_OFF_PRIORITY_HIGH_BITS: regRead = {26'h0, prioHighReg};
        `CASB_OFF_PRIORITY_LOW_BITS: regRead = {26'h0, prioLowReg};
        // R19 selected pointer bytes
        `CASB_OFF_POINTER_LOW: regRead = {24'h0, selPtr[7:0]};
        `CASB_OFF_POINTER_HIGH: regRead = {24'h0, selPtr[15:8]};
        `CASB_OFF_LEVEL_STATUS:
          regRead = {29'h0, levelStackReg[stackDepthReg]};
        `CASB_OFF_SERVICE: regRead = {30'h0, stackDepthReg};
        default: regRead = 32'h0;
      endcase
    end
  endfunction
  // Index sits in bits 9..2; a byte offset into a word is refused
  function isMapped;
    input [31:0] addr;
    begin
      case (addr[9:2])
        `CASB_OFF_AUX_CONTROL, `CASB_OFF_POINTER_SELECT_AUX,
        `CASB_OFF_PRIORITY_HIGH_BITS, `CASB_OFF_PRIORITY_LOW_BITS,
        `CASB_OFF_POINTER_LOW, `CASB_OFF_POINTER_HIGH,
        `CASB_OFF_LEVEL_STATUS, `CASB_OFF_SERVICE:
          isMapped = (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0);
        default: isMapped = 1'b0;
      endcase
    end
  endfunction
  // ***************************************************************
  // Write channel capture
  // ***************************************************************
  wire wrFire = awTakenReg && wTakenReg && !s_axi_bvalid;
  wire [7:0] wByte = wDataReg[7:0];
  wire wrHit = wrFire && wStrbReg[0] && (awAddrReg != 8'hFF);
  // Address and data taken in either order, held until the response
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awTakenReg <= 1'b0;
      wTakenReg <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h0;
      wStrbReg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CASB_RESP_OKAY;
    end else begin
      s_axi_awready <= !awTakenReg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wTakenReg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awTakenReg <= 1'b1;
        // Unmapped addresses collapse onto a marker that matches nothing
        awAddrReg <= isMapped(s_axi_awaddr) ? s_axi_awaddr[9:2] : 8'hFF;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTakenReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddrReg == 8'hFF) ? `CASB_RESP_SLVERR :
                       `CASB_RESP_OKAY;
        awTakenReg <= 1'b0;
        wTakenReg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ***************************************************************
  // Read channel
  // ***************************************************************
  // One read at a time; answer one cycle after the address is taken
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CASB_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= isMapped(s_axi_araddr) ?
                       regRead(s_axi_araddr[9:2]) : 32'h0;
        s_axi_rresp <= isMapped(s_axi_araddr) ? `CASB_RESP_OKAY :
                       `CASB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ***************************************************************
  // Control and priority registers
  // ***************************************************************
  // Bus writes take effect on the cycle the response is raised
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      // R20 clear at reset
      strobeOffReg <= 1'b0;
      prioLowReg <= `CASB_RST_PRIORITY;
      prioHighReg <= `CASB_RST_PRIORITY;
      // R09 select resets zero
      selReg <= 1'b0;
      userFlagReg <= 1'b0;
    end else if (wrHit) begin
      case (awAddrReg)
        `CASB_OFF_AUX_CONTROL: strobeOffReg <= wByte[`CASB_BIT_STROBE_OFF];
        `CASB_OFF_POINTER_SELECT_AUX: begin
          // R11 increment toggles select only
          // R12 flag stored plainly
          selReg <= wByte[`CASB_BIT_POINTER_SELECT];
          userFlagReg <= wByte[`CASB_BIT_USER_FLAG];
        end
        // R01 one raises, zero lowers
        // R03 high bits same order
        `CASB_OFF_PRIORITY_HIGH_BITS: prioHighReg <= wByte[NSRC-1:0];
        // R02 six low bits
        `CASB_OFF_PRIORITY_LOW_BITS: prioLowReg <= wByte[NSRC-1:0];
        default: selReg <= selReg;
      endcase
    end
  end
  // ***************************************************************
  // Dual data pointer
  // ***************************************************************
  // R08 two independent pointers
  // Bus byte writes and core operations share a port; the bus wins
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ptrZeroReg <= `CASB_RST_POINTER;
      ptrOneReg <= `CASB_RST_POINTER;
    end else begin
      // R19 byte-wise access
      if (wrHit && awAddrReg == `CASB_OFF_POINTER_LOW) begin
        if (selReg) ptrOneReg[7:0] <= wByte;
        else ptrZeroReg[7:0] <= wByte;
      end else if (wrHit && awAddrReg == `CASB_OFF_POINTER_HIGH) begin
        if (selReg) ptrOneReg[15:8] <= wByte;
        else ptrZeroReg[15:8] <= wByte;
      end else if (ptrOp == `CASB_OP_INC) begin
        // R14 selected pointer only
        // R15 increment by one
        if (selReg) ptrOneReg <= ptrOneReg + 16'h0001;
        else ptrZeroReg <= ptrZeroReg + 16'h0001;
      end else if (ptrOp == `CASB_OP_LOAD) begin
        // R15 load constant
        if (selReg) ptrOneReg <= ptrData;
        else ptrZeroReg <= ptrData;
      end
    end
  end
  // ***************************************************************
  // Pointer-addressed memory and jump requests
  // ***************************************************************
  wire [PW-1:0] accSum = selPtr + {8'h00, accValue};
  // Requests are registered one cycle after the operation code
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      memAddr <= 16'h0000;
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memCode <= 1'b0;
      memWdata <= 8'h00;
      jumpValid <= 1'b0;
      jumpTarget <= 16'h0000;
    end else begin
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memCode <= 1'b0;
      jumpValid <= 1'b0;
      case (ptrOp)
        `CASB_OP_XDATA: begin
          // R16 full pointer address
          memAddr <= selPtr;
          memRead <= !xdataWrite;
          memWrite <= xdataWrite;
          memWdata <= accValue;
        end
        `CASB_OP_CODE: begin
          // R17 acc plus pointer
          memAddr <= accSum;
          memCode <= 1'b1;
        end
        `CASB_OP_JUMP: begin
          // R18 jump acc plus pointer
          jumpTarget <= accSum;
          jumpValid <= 1'b1;
        end
        default: memAddr <= memAddr;
      endcase
    end
  end

  // ***************************************************************
  // Strobe gating
  // ***************************************************************
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      strobeOut <= 1'b0;
    end else begin
      // R07 suppress strobe
      strobeOut <= strobeReq && !strobeOffReg;
    end
  end

  // ***************************************************************
  // Level arbitration and preemption
  // ***************************************************************
  reg [2:0] bestLvl;
  reg [2:0] bestSrc;
  reg found;
  integer i;
  // Highest level wins; lower index wins a tie (polling order)
  always @* begin
    bestLvl = 3'h0;
    bestSrc = 3'h0;
    found = 1'b0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (irqPending[i] &&
          (!found || {1'b0, srcLevel(prioHighReg, prioLowReg, i)} >=
           bestLvl)) begin
        found = 1'b1;
        bestLvl = {1'b0, srcLevel(prioHighReg, prioLowReg, i)};
        bestSrc = i[2:0];
      end
    end
  end
  wire [2:0] curLvl = levelStackReg[stackDepthReg];
  // R06 strictly higher preempts
  wire canTake = found && (curLvl == 3'h4 || bestLvl > curLvl) &&
                 !(stackDepthReg == 2'h3 && curLvl != 3'h4);
  // Nest stack: slot 0 idle, a take from idle fills the current slot, a preempting take pushes, each done pops back
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stackDepthReg <= 2'h0;
      levelStackReg[0] <= 3'h4;
      levelStackReg[1] <= 3'h4;
      levelStackReg[2] <= 3'h4;
      levelStackReg[3] <= 3'h4;
      irqTake <= 1'b0;
      irqSource <= 3'h0;
    end else begin
      irqTake <= 1'b0;
      if (irqDone && curLvl != 3'h4) begin
        // R06 resume preempted handler
        levelStackReg[stackDepthReg] <= 3'h4;
        if (stackDepthReg != 2'h0) stackDepthReg <= stackDepthReg - 2'h1;
      end else if (canTake) begin
        irqTake <= 1'b1;
        irqSource <= bestSrc;
        if (curLvl == 3'h4) begin
          levelStackReg[stackDepthReg] <= bestLvl;
        end else begin
          stackDepthReg <= stackDepthReg + 2'h1;
          levelStackReg[stackDepthReg + 2'h1] <= bestLvl;
        end
      end
    end
  end

endmodule // casb_core_aux_sfr_bank
